// file: include/acfd_pkg.sv
// constants and register layout for the converter configuration decode block
package acfd_pkg;

  // ----------------------------------------------------------------
  // bus and result widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W   = 3;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned RES_W    = 10;
  localparam int unsigned DIV_W    = 5;

  typedef logic [ADDR_W-1:0] acfd_addr_t;
  typedef logic [DATA_W-1:0] acfd_byte_t;
  typedef logic [RES_W-1:0]  acfd_res_t;

  // ----------------------------------------------------------------
  // register indexes
  // ----------------------------------------------------------------
  localparam acfd_addr_t REG_CFG    = 3'h0;
  localparam acfd_addr_t REG_CTRL   = 3'h1;
  localparam acfd_addr_t REG_RES_HI = 3'h2;
  localparam acfd_addr_t REG_RES_LO = 3'h3;
  localparam acfd_addr_t REG_STAT   = 3'h4;
  localparam acfd_addr_t REG_DIVCNT = 3'h5;

  // ----------------------------------------------------------------
  // configuration register fields
  // ----------------------------------------------------------------
  localparam int unsigned CFG_DIV_LSB   = 3;
  localparam int unsigned CFG_DIV_MSB   = 7;
  localparam int unsigned CFG_LJST_BIT  = 2;
  localparam int unsigned CFG_EIGHT_BIT = 1;
  localparam int unsigned CFG_GAIN_BIT  = 0;

  // ----------------------------------------------------------------
  // control and status fields
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_MPC_EN_BIT = 0;
  localparam int unsigned STAT_READY_BIT  = 0;
  localparam int unsigned STAT_OVR_BIT    = 1;
  localparam int unsigned STAT_DFAULT_BIT = 2;
  localparam int unsigned STAT_EIGHT_BIT  = 3;

  // ----------------------------------------------------------------
  // reset values and fixed patterns
  // ----------------------------------------------------------------
  localparam acfd_byte_t CFG_RST    = 8'h00;
  localparam acfd_byte_t CTRL_RST   = 8'h00;
  localparam acfd_res_t  RES_RST    = 10'h000;
  localparam acfd_byte_t BYTE_ZERO  = 8'h00;
  localparam logic [DIV_W-1:0] DIV_MIN_MPC_EN = 5'h01;

endpackage

// file: src/acfd_clk_div.sv
// converter clock divider: one enable pulse per converter clock period
`timescale 1ns/1ps
module acfd_clk_div #(
  parameter int unsigned DIV_W = 5
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [DIV_W-1:0] div_i,
  output logic                  tick_o,
  output logic [DIV_W-1:0]      count_o
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (DIV_W < 1) begin : g_chk
    $error("divider width must be at least one");
  end

  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] cnt_d;
  logic             tick_q;
  logic             tick_d;

  // ----------------------------------------------------------------
  // period of div plus one system clocks
  // ----------------------------------------------------------------
  always_comb begin
    // compare with >= so a lowered divider never strands the counter
    if (cnt_q >= div_i) begin
      cnt_d  = '0;
      tick_d = 1'b1;
    end else begin
      cnt_d  = cnt_q + 1'b1;
      tick_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o  = tick_q;
  assign count_o = cnt_q;

endmodule

// file: src/acfd_fmt.sv
// places a raw conversion result into the high and low result bytes
`timescale 1ns/1ps
module acfd_fmt
  import acfd_pkg::*;
(
  input  wire acfd_pkg::acfd_res_t  raw_i,
  input  wire logic                 left_i,
  input  wire logic                 eight_i,
  output acfd_pkg::acfd_byte_t      high_o,
  output acfd_pkg::acfd_byte_t      low_o
);

  always_comb begin
    if (eight_i) begin
      // justify ignored, msbs of the converter word land in the low byte
      high_o = BYTE_ZERO;
      low_o  = raw_i[RES_W-1:RES_W-DATA_W];
    end else if (left_i) begin
      high_o = raw_i[RES_W-1:RES_W-DATA_W];
      low_o  = {raw_i[RES_W-DATA_W-1:0], {(2*DATA_W-RES_W){1'b0}}};
    end else begin
      high_o = {{(2*DATA_W-RES_W){1'b0}}, raw_i[RES_W-1:DATA_W]};
      low_o  = raw_i[DATA_W-1:0];
    end
  end

endmodule

// file: src/acfd_top.sv
// converter setup register decode, result placement and clock divider
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module acfd_top
  import acfd_pkg::*;
#(
  parameter int unsigned DIV_WIDTH = 5
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire acfd_pkg::acfd_addr_t addr_i,
  input  wire acfd_pkg::acfd_byte_t wdata_i,
  input  wire logic                 we_i,
  input  wire logic                 re_i,
  output acfd_pkg::acfd_byte_t      rdata_o,
  input  wire acfd_pkg::acfd_res_t  result_i,
  input  wire logic                 result_valid_i,
  output logic                      conv_tick_o,
  output logic                      eight_bit_mode_o,
  output logic                      input_gain_unity_o,
  output logic                      mpc_enable_o,
  output logic                      div_fault_o,
  output logic                      result_ready_o,
  output acfd_pkg::acfd_byte_t      result_high_o,
  output acfd_pkg::acfd_byte_t      result_low_o
);

  import acfd_pkg::*;

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  // the field is fixed at bits 7:3, so no other width can be decoded
  if (DIV_WIDTH != DIV_W) begin : g_chk
    $error("divider width must match the configuration field");
  end

  // placement pads with zeros, so the word must exceed one byte and stay below two
  if (RES_W <= DATA_W || RES_W >= 2*DATA_W) begin : g_chk_res
    $error("result width must lie between one and two bytes");
  end

  // the divider field is cut from the setup byte by its two end positions
  if (CFG_DIV_MSB - CFG_DIV_LSB + 1 != DIV_W) begin : g_chk_fld
    $error("divider field position does not match its width");
  end

  // the count register zero-extends the divider count into one byte
  if (DIV_W > DATA_W) begin : g_chk_cnt
    $error("divider count must fit one byte");
  end

  // status bits must fit the one status byte, as the setup and control fields fit theirs
  if (STAT_EIGHT_BIT >= DATA_W) begin : g_chk_stat
    $error("status layout must fit one byte");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic hit_wr(input acfd_addr_t a,
                                  input acfd_addr_t r,
                                  input logic w);
    hit_wr = w && (a == r);
  endfunction

  function automatic logic bit_of(input acfd_byte_t v,
                                  input int unsigned pos);
    bit_of = v[pos];
  endfunction

  // ----------------------------------------------------------------
  // configuration and control registers
  // ----------------------------------------------------------------
  acfd_byte_t cfg_q;
  acfd_byte_t cfg_d;
  acfd_byte_t ctrl_q;
  acfd_byte_t ctrl_d;

  always_comb begin
    cfg_d  = cfg_q;
    ctrl_d = ctrl_q;
    if (hit_wr(addr_i, REG_CFG, we_i)) begin
      cfg_d = wdata_i;
    end
    if (hit_wr(addr_i, REG_CTRL, we_i)) begin
      // only the power controller enable is kept, the rest reads zero
      ctrl_d = BYTE_ZERO;
      ctrl_d[CTRL_MPC_EN_BIT] = wdata_i[CTRL_MPC_EN_BIT];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_q  <= CFG_RST;
      ctrl_q <= CTRL_RST;
    end else begin
      cfg_q  <= cfg_d;
      ctrl_q <= ctrl_d;
    end
  end

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  logic [DIV_W-1:0] div_field;
  logic             ljst_sel;
  logic             eight_sel;
  logic             gain_sel;
  logic             mpc_en;

  assign div_field = cfg_q[CFG_DIV_MSB:CFG_DIV_LSB];
  assign ljst_sel  = bit_of(cfg_q, CFG_LJST_BIT);
  assign eight_sel = bit_of(cfg_q, CFG_EIGHT_BIT);
  assign gain_sel  = bit_of(cfg_q, CFG_GAIN_BIT);
  assign mpc_en    = bit_of(ctrl_q, CTRL_MPC_EN_BIT);

  // ----------------------------------------------------------------
  // converter clock divider
  // ----------------------------------------------------------------
  logic [DIV_W-1:0] div_count;

  acfd_clk_div #(
    .DIV_W   (DIV_W)
  ) u_div (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .div_i   (div_field),
    .tick_o  (conv_tick_o),
    .count_o (div_count)
  );

  // ----------------------------------------------------------------
  // result capture and status
  // ----------------------------------------------------------------
  // raw word is kept, so changing justify or width re-places old data
  acfd_res_t raw_q;
  acfd_res_t raw_d;
  logic      ready_q;
  logic      ready_d;
  logic      ovr_q;
  logic      ovr_d;
  logic      stat_wr;

  assign stat_wr = hit_wr(addr_i, REG_STAT, we_i);

  always_comb begin
    raw_d   = raw_q;
    ready_d = ready_q;
    ovr_d   = ovr_q;
    // write one to clear first, so a fresh event below overrides it
    if (stat_wr && wdata_i[STAT_READY_BIT]) begin
      ready_d = 1'b0;
    end
    if (stat_wr && wdata_i[STAT_OVR_BIT]) begin
      ovr_d = 1'b0;
    end
    if (result_valid_i) begin
      raw_d   = result_i;
      ready_d = 1'b1;
      if (ready_q) begin
        ovr_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      raw_q   <= RES_RST;
      ready_q <= 1'b0;
      ovr_q   <= 1'b0;
    end else begin
      raw_q   <= raw_d;
      ready_q <= ready_d;
      ovr_q   <= ovr_d;
    end
  end

  // ----------------------------------------------------------------
  // result placement
  // ----------------------------------------------------------------
  acfd_byte_t fmt_high;
  acfd_byte_t fmt_low;

  acfd_fmt u_fmt (
    .raw_i   (raw_q),
    .left_i  (ljst_sel),
    .eight_i (eight_sel),
    .high_o  (fmt_high),
    .low_o   (fmt_low)
  );

  // ----------------------------------------------------------------
  // divider lower limit watch
  // ----------------------------------------------------------------
  // the device cannot fix a bad setting, it only reports it
  logic dfault_q;
  logic dfault_d;

  always_comb begin
    dfault_d = mpc_en && (div_field < DIV_MIN_MPC_EN);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dfault_q <= 1'b0;
    end else begin
      dfault_q <= dfault_d;
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  // every data pin leaves a flop, at the cost of one cycle of lag
  acfd_byte_t res_hi_q;
  acfd_byte_t res_hi_d;
  acfd_byte_t res_lo_q;
  acfd_byte_t res_lo_d;
  logic       eight_q;
  logic       eight_d;
  logic       gain_q;
  logic       gain_d;
  logic       mpc_en_q;
  logic       mpc_en_d;

  always_comb begin
    res_hi_d = fmt_high;
    res_lo_d = fmt_low;
    eight_d  = eight_sel;
    gain_d   = gain_sel;
    mpc_en_d = mpc_en;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      res_hi_q <= BYTE_ZERO;
      res_lo_q <= BYTE_ZERO;
      eight_q  <= 1'b0;
      gain_q   <= 1'b0;
      mpc_en_q <= 1'b0;
    end else begin
      res_hi_q <= res_hi_d;
      res_lo_q <= res_lo_d;
      eight_q  <= eight_d;
      gain_q   <= gain_d;
      mpc_en_q <= mpc_en_d;
    end
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  // read data stand one cycle and then fall to zero
  acfd_byte_t rdata_q;
  acfd_byte_t rdata_d;
  acfd_byte_t stat_val;

  always_comb begin
    stat_val = BYTE_ZERO;
    stat_val[STAT_READY_BIT]  = ready_q;
    stat_val[STAT_OVR_BIT]    = ovr_q;
    stat_val[STAT_DFAULT_BIT] = dfault_q;
    stat_val[STAT_EIGHT_BIT]  = eight_sel;
  end

  always_comb begin
    rdata_d = BYTE_ZERO;
    if (re_i) begin
      if (addr_i == REG_CFG) begin
        rdata_d = cfg_q;
      end else if (addr_i == REG_CTRL) begin
        rdata_d = ctrl_q;
      end else if (addr_i == REG_RES_HI) begin
        rdata_d = fmt_high;
      end else if (addr_i == REG_RES_LO) begin
        rdata_d = fmt_low;
      end else if (addr_i == REG_STAT) begin
        rdata_d = stat_val;
      end else if (addr_i == REG_DIVCNT) begin
        rdata_d = {{(DATA_W-DIV_W){1'b0}}, div_count};
      end else begin
        rdata_d = BYTE_ZERO;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= BYTE_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // output drive
  // ----------------------------------------------------------------
  assign rdata_o            = rdata_q;
  assign eight_bit_mode_o   = eight_q;
  assign input_gain_unity_o = gain_q;
  assign mpc_enable_o       = mpc_en_q;
  assign div_fault_o        = dfault_q;
  assign result_ready_o     = ready_q;
  assign result_high_o      = res_hi_q;
  assign result_low_o       = res_lo_q;

endmodule

// file: verif/acfd_top_sva.sv
// concurrent assertions for the converter setup decode block
`timescale 1ns/1ps
module acfd_top_sva
  import acfd_pkg::*;
#(
  parameter int unsigned DIV_WIDTH = 5
) (
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire acfd_pkg::acfd_addr_t addr_i,
  input wire acfd_pkg::acfd_byte_t wdata_i,
  input wire logic                 we_i,
  input wire logic                 re_i,
  input wire acfd_pkg::acfd_byte_t rdata_o,
  input wire acfd_pkg::acfd_res_t  result_i,
  input wire logic                 result_valid_i,
  input wire logic                 conv_tick_o,
  input wire logic                 eight_bit_mode_o,
  input wire logic                 input_gain_unity_o,
  input wire logic                 mpc_enable_o,
  input wire logic                 div_fault_o,
  input wire acfd_pkg::acfd_byte_t result_high_o,
  input wire acfd_pkg::acfd_byte_t result_low_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------
  // shadow of the setup byte and raw word, same timing as the block
  // ----------------------------------------------------------------
  acfd_byte_t cfg_q, cfg_d;
  acfd_res_t  raw_q, raw_d;

  always_comb begin
    cfg_d = (we_i && addr_i == REG_CFG) ? wdata_i : cfg_q;
    raw_d = result_valid_i ? result_i : raw_q;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_q <= CFG_RST;
      raw_q <= RES_RST;
    end else begin
      cfg_q <= cfg_d;
      raw_q <= raw_d;
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  gain_copy_a: assert property (we_i && addr_i == REG_CFG |=> ##1
    input_gain_unity_o == $past(wdata_i[0], 2)) else $error("gain select copy wrong");
  eight_copy_a: assert property (we_i && addr_i == REG_CFG |=> ##1
    eight_bit_mode_o == $past(wdata_i[1], 2)) else $error("width select copy wrong");
  right_place_a: assert property (!eight_bit_mode_o && !$past(cfg_q[2]) |->
    result_high_o == {6'h00, $past(raw_q[9:8])} && result_low_o == $past(raw_q[7:0]))
    else $error("right placement wrong");
  left_place_a: assert property (!eight_bit_mode_o && $past(cfg_q[2]) |->
    result_high_o == $past(raw_q[9:2]) && result_low_o == {$past(raw_q[1:0]), 6'h00})
    else $error("left placement wrong");
  eight_place_a: assert property (eight_bit_mode_o |->
    result_high_o == BYTE_ZERO && result_low_o == $past(raw_q[9:2]))
    else $error("eight bit placement wrong");
  zero_div_a: assert property (!$past(rst_i) && $past(cfg_q[7:3], 2) == 5'h00 &&
    $past(cfg_q[7:3]) == 5'h00 && cfg_q[7:3] == 5'h00 |-> conv_tick_o)
    else $error("zero divider must tick every cycle");
  div_fault_a: assert property (
    div_fault_o == (mpc_enable_o && $past(cfg_q[7:3]) == 5'h00))
    else $error("divider fault flag wrong");
  cfg_read_a: assert property (re_i && addr_i == REG_CFG |=>
    rdata_o == $past(cfg_q)) else $error("setup readback wrong");
endmodule

bind acfd_top acfd_top_sva #(.DIV_WIDTH(DIV_WIDTH)) u_sva (
  .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
  .re_i(re_i), .rdata_o(rdata_o), .result_i(result_i), .result_valid_i(result_valid_i),
  .conv_tick_o(conv_tick_o), .eight_bit_mode_o(eight_bit_mode_o),
  .input_gain_unity_o(input_gain_unity_o), .mpc_enable_o(mpc_enable_o),
  .div_fault_o(div_fault_o), .result_high_o(result_high_o), .result_low_o(result_low_o));

// file: verif/acfd_top_tb.sv
// self-checking testbench for the converter setup decode block
`timescale 1ns/1ps
module acfd_top_tb;
  import acfd_pkg::*;
  logic       clk_i, rst_i, we_i, re_i, result_valid_i;
  acfd_addr_t addr_i;
  acfd_byte_t wdata_i, rdata_o, result_high_o, result_low_o;
  acfd_res_t  result_i;
  logic       conv_tick_o, eight_bit_mode_o, input_gain_unity_o;
  logic       mpc_enable_o, div_fault_o, result_ready_o;
  int         error_cnt = 0;
  int         checks_done = 0;

  acfd_top #(.DIV_WIDTH(5)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
    .re_i(re_i), .rdata_o(rdata_o), .result_i(result_i), .result_valid_i(result_valid_i),
    .conv_tick_o(conv_tick_o), .eight_bit_mode_o(eight_bit_mode_o),
    .input_gain_unity_o(input_gain_unity_o), .mpc_enable_o(mpc_enable_o),
    .div_fault_o(div_fault_o), .result_ready_o(result_ready_o),
    .result_high_o(result_high_o), .result_low_o(result_low_o));

  // ----------------------------------------------------------------
  // bus and compare helpers
  // ----------------------------------------------------------------
  task automatic chk8(input acfd_byte_t got, input acfd_byte_t exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic wr(input acfd_addr_t a, input acfd_byte_t d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    we_i    <= 1'b1;
    @(posedge clk_i);
    we_i    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input acfd_addr_t a, input acfd_byte_t exp);
    @(posedge clk_i);
    addr_i <= a;
    re_i   <= 1'b1;
    @(posedge clk_i);
    re_i   <= 1'b0;
    #1;
    chk8(rdata_o, exp);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_modes();
    acfd_byte_t c;
    for (int i = 0; i < 4; i++) begin
      c = {5'h13, 1'b0, i[1:0]};
      wr(REG_CFG, c);
      cyc(2);
      chk1(eight_bit_mode_o, c[CFG_EIGHT_BIT]);
      chk1(input_gain_unity_o, c[CFG_GAIN_BIT]);
      rd(REG_CFG, c);
    end
  endtask

  task automatic t_place(input logic lj, input logic eb, input acfd_res_t r);
    acfd_byte_t hi, lo;
    wr(REG_CFG, {5'h01, lj, eb, 1'b1});
    @(posedge clk_i);
    result_i       <= r;
    result_valid_i <= 1'b1;
    @(posedge clk_i);
    result_valid_i <= 1'b0;
    cyc(2);
    hi = eb ? BYTE_ZERO : (lj ? r[9:2] : {6'h00, r[9:8]});
    lo = eb ? r[9:2] : (lj ? {r[1:0], 6'h00} : r[7:0]);
    chk8(result_high_o, hi);
    chk8(result_low_o, lo);
    rd(REG_RES_HI, hi);
    rd(REG_RES_LO, lo);
  endtask

  // spacing between two ticks is the field plus one
  task automatic t_div(input logic [4:0] f);
    int n;
    wr(REG_CFG, {f, 3'h0});
    cyc(3);
    n = 0;
    while (conv_tick_o !== 1'b1 && n < 64) begin
      cyc(1);
      n++;
    end
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (conv_tick_o !== 1'b1 && n < 64);
    chk8(8'(n), 8'(f) + 8'h01);
  endtask

  task automatic t_fault();
    wr(REG_CTRL, 8'h01);
    wr(REG_CFG, 8'h00);
    cyc(2);
    chk1(mpc_enable_o, 1'b1);
    chk1(div_fault_o, 1'b1);
    wr(REG_CFG, 8'h08);
    cyc(2);
    chk1(div_fault_o, 1'b0);
    wr(REG_CTRL, 8'h00);
  endtask

  // a fresh result must win over a clear written in the same cycle
  task automatic t_stat();
    wr(REG_CFG, 8'h00);
    wr(REG_STAT, 8'h03);
    cyc(1);
    chk1(result_ready_o, 1'b0);
    rd(REG_STAT, BYTE_ZERO);
    rd(REG_DIVCNT, BYTE_ZERO);
    @(posedge clk_i);
    result_valid_i <= 1'b1;
    @(posedge clk_i);
    result_valid_i <= 1'b0;
    cyc(1);
    chk1(result_ready_o, 1'b1);
    rd(REG_STAT, 8'h01);
    @(posedge clk_i);
    addr_i         <= REG_STAT;
    wdata_i        <= 8'h01;
    we_i           <= 1'b1;
    result_valid_i <= 1'b1;
    @(posedge clk_i);
    we_i           <= 1'b0;
    result_valid_i <= 1'b0;
    rd(REG_STAT, 8'h03);
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  initial begin
    rst_i          = 1'b1;
    we_i           = 1'b0;
    re_i           = 1'b0;
    result_valid_i = 1'b0;
    addr_i         = REG_CFG;
    wdata_i        = 8'h00;
    result_i       = 10'h000;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    cyc(1);
    chk8(result_high_o, BYTE_ZERO);
    rd(REG_CFG, CFG_RST);
    t_modes();
    t_place(1'b0, 1'b0, 10'h2A5);
    t_place(1'b1, 1'b0, 10'h15A);
    t_place(1'b0, 1'b1, 10'h3C3);
    t_place(1'b1, 1'b1, 10'h0FF);
    t_div(5'h00);
    t_div(5'h02);
    t_div(5'h1F);
    t_fault();
    t_stat();
    end_sim();
  end

  // whole run needs well under a thousand cycles
  initial begin
    #100000;
    error_cnt++;
    end_sim();
  end
endmodule
